// >>> rtl/rx_prot_pkg.sv
// Constants shared by the receiver protection and event manager.
// Assumes converter readings in mV, mA and degrees C, one code per unit.
package rx_prot_pkg;
  localparam int PIN_COUNT = 6;
  localparam int FUNC_W = 8;
  localparam int RD_W = 16;
  localparam int T_W = 8;
  localparam int ACT_W = 3;
  // Action set bit positions
  localparam int ACT_PACKET = 0;
  localparam int ACT_DISC = 1;
  localparam int ACT_INT = 2;
  // Interrupt source positions
  localparam int IRQ_N = 9;
  localparam int IRQ_HARD_OVP = 0;
  localparam int IRQ_FIXED_SOFT_OVP = 1;
  localparam int IRQ_ADJ_SOFT_OVP = 2;
  localparam int IRQ_TEMP_RECT = 3;
  localparam int IRQ_TEMP_REG = 4;
  localparam int IRQ_TEMP_COIL = 5;
  localparam int IRQ_CURRENT_LIMIT = 6;
  localparam int IRQ_SHORT = 7;
  localparam int IRQ_OVERLOAD = 8;
  // Synchroniser slot positions
  localparam int SYNC_W = 3 + PIN_COUNT;
  localparam int S_HARD_OVP = 0;
  localparam int S_FIXED_OVP = 1;
  localparam int S_FIVE_V_GOOD = 2;
  localparam int S_PIN0 = 3;
  // Fixed analog limits, hysteresis and step sizes
  localparam logic [RD_W-1:0] CURRENT_LIMIT_MA = 16'h05DC;
  localparam logic [RD_W-1:0] SHORT_LIMIT_MV = 16'h04E2;
  localparam logic [T_W-1:0] TEMP_HARD_C = 8'h7D;
  localparam logic [T_W-1:0] TEMP_HYST_C = 8'h0A;
  localparam logic [RD_W-1:0] TARGET_STEP_MV = 16'h0019;
  localparam logic [RD_W-1:0] DUMMY_STEP_MA = 16'h0001;
  // Pin function codes
  localparam logic [FUNC_W-1:0] PIN_FUNC_UNUSED = 8'h00;
  localparam logic [FUNC_W-1:0] PIN_FUNC_IRQ_INV_OPENDRAIN = 8'h03;
  localparam logic [FUNC_W-1:0] PIN_FUNC_IRQ_INV_PUSHPULL = 8'h04;
  localparam logic [FUNC_W-1:0] PIN_FUNC_OUTPUT_INHIBIT_IN = 8'h05;
  localparam logic [FUNC_W-1:0] PIN_FUNC_OUTPUT_STATUS = 8'h06;
  localparam logic [FUNC_W-1:0] PIN_FUNC_OUTPUT_STATUS_INV = 8'h07;
  localparam logic [FUNC_W-1:0] PIN_FUNC_OUTPUT_STATUS_INV_OD = 8'h08;
  localparam logic [FUNC_W-1:0] PIN_FUNC_SAMPLE_TICK = 8'h0F;
  localparam logic [FUNC_W-1:0] PIN_FUNC_CORE_READY_N = 8'h1D;
endpackage : rx_prot_pkg

// >>> rtl/rx_protection_event_manager.sv
// Protection, regulator supervision and pin function logic of the receiver.
// Assumes analog comparators on async pins and converter readings on SYS_CLK_I.
// Behaviour
// - Output target follows nominal voltage setting.
// - Fixed current limit lowers output target.
// - Input loop flags rectified rail below minimum.
// - Dummy current starts full, fades with load.
// - Hard over-voltage clamps coil terminals at once.
// - Clamp held until five-volt supply drops.
// - Either soft over-voltage pulls external clamp low.
// - Adjustable soft over-voltage compared on readings.
// - Over-voltage may request end-transfer packet.
// - Die temperatures readable on dedicated outputs.
// - Die temperature 125C with hysteresis clamps.
// - Three temperature thresholds with action sets.
// - Current limit raises interrupt with actions.
// - Output below 1.25V disables regulator, interrupts.
// - Programmable overload alert with action set.
// - Each pin input, push-pull or open-drain.
// - Interrupt pin mappable, push-pull or open-drain.
// - Codes 0x03, 0x04 interrupt pin functions, 0x00 unused.
// - Code 0x05 input inhibits output when high.
// - Codes 0x06 to 0x08 show output status.
// - Code 0x0F sample ticker, 0x1D core ready.
// - Reset holds core, release reloads configuration.
`timescale 1ns/1ps
module rx_protection_event_manager #(
  parameter int PINS = rx_prot_pkg::PIN_COUNT
) (
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  input wire logic HARD_OVP_I,
  input wire logic FIXED_SOFT_OVP_I,
  input wire logic FIVE_V_GOOD_I,
  input wire logic ADC_VALID_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] ADC_RECTIFIED_RAIL_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] ADC_OUTPUT_RAIL_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] ADC_IOUT_I,
  input wire logic [rx_prot_pkg::T_W-1:0] ADC_TEMP_RECT_I,
  input wire logic [rx_prot_pkg::T_W-1:0] ADC_TEMP_REG_I,
  input wire logic [rx_prot_pkg::T_W-1:0] ADC_TEMP_COIL_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] OUTPUT_RAIL_NOMINAL_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] RECTIFIED_RAIL_MIN_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] DUMMY_CURRENT_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] ADJ_OVP_TH_I,
  input wire logic [rx_prot_pkg::RD_W-1:0] OVERLOAD_TH_I,
  input wire logic [3*rx_prot_pkg::T_W-1:0] TEMP_TH_I,
  input wire logic [rx_prot_pkg::IRQ_N*rx_prot_pkg::ACT_W-1:0] ACTION_I,
  input wire logic [rx_prot_pkg::IRQ_N-1:0] IRQ_MAP_I,
  input wire logic [rx_prot_pkg::IRQ_N-1:0] IRQ_CLEAR_I,
  input wire logic INT_OPEN_DRAIN_I,
  input wire logic CONFIG_DONE_I,
  input wire logic [PINS*rx_prot_pkg::FUNC_W-1:0] PIN_FUNC_SEL_I,
  input wire logic [PINS-1:0] PIN_I,
  output logic [PINS-1:0] PIN_O,
  output logic [PINS-1:0] PIN_OE_O,
  output logic INT_N_O,
  output logic INT_OE_O,
  output logic COIL_CLAMP_O,
  output logic EXT_CLAMP_N_O,
  output logic END_TRANSFER_PACKET_O,
  output logic REG_DISABLE_O,
  output logic OUTPUT_ENABLED_O,
  output logic CURRENT_LOOP_O,
  output logic INPUT_LOOP_O,
  output logic [rx_prot_pkg::RD_W-1:0] OUTPUT_RAIL_TARGET_O,
  output logic [rx_prot_pkg::RD_W-1:0] RECTIFIED_RAIL_MIN_O,
  output logic [rx_prot_pkg::RD_W-1:0] DUMMY_CURRENT_O,
  output logic [rx_prot_pkg::T_W-1:0] TEMP_RECT_O,
  output logic [rx_prot_pkg::T_W-1:0] TEMP_REG_O,
  output logic [rx_prot_pkg::IRQ_N-1:0] IRQ_STATUS_O,
  output logic CONFIG_RELOAD_O,
  output logic CORE_READY_O
);
  localparam int SW = 3 + PINS;
  localparam int RW = rx_prot_pkg::RD_W;
  localparam int TW = rx_prot_pkg::T_W;
  localparam int NI = rx_prot_pkg::IRQ_N;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);

  // Two-stage synchronisers for async inputs
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {PIN_I, FIVE_V_GOOD_I, FIXED_SOFT_OVP_I, HARD_OVP_I};
      sync2_r <= sync1_r;
    end
  end
  wire logic hard_ovp_s = sync2_r[rx_prot_pkg::S_HARD_OVP];
  wire logic fixed_ovp_s = sync2_r[rx_prot_pkg::S_FIXED_OVP];
  wire logic five_good_s = sync2_r[rx_prot_pkg::S_FIVE_V_GOOD];

  // Measurement group, updated on converter samples; vmin_r follows its setting every cycle
  logic [TW-1:0] temp_rect_r, temp_rect_nxt, temp_reg_r, temp_reg_nxt;
  logic [RW-1:0] vmin_r, vmin_nxt;
  logic adj_ovp_r, adj_ovp_nxt, ilim_r, ilim_nxt, short_r, short_nxt;
  logic overload_r, overload_nxt, inloop_r, inloop_nxt, hot_r, hot_nxt;
  logic tick_r, tick_nxt;
  logic [2:0] tuser_r, tuser_nxt;
  always_comb begin
    temp_rect_nxt = temp_rect_r;
    temp_reg_nxt = temp_reg_r;
    vmin_nxt = RECTIFIED_RAIL_MIN_I;
    adj_ovp_nxt = adj_ovp_r;
    ilim_nxt = ilim_r;
    short_nxt = short_r;
    overload_nxt = overload_r;
    inloop_nxt = inloop_r;
    hot_nxt = hot_r;
    tick_nxt = tick_r;
    tuser_nxt = tuser_r;
    if (ADC_VALID_I) begin
      temp_rect_nxt = ADC_TEMP_RECT_I;
      temp_reg_nxt = ADC_TEMP_REG_I;
      adj_ovp_nxt = ADC_RECTIFIED_RAIL_I > ADJ_OVP_TH_I;
      ilim_nxt = ADC_IOUT_I >= rx_prot_pkg::CURRENT_LIMIT_MA;
      short_nxt = ADC_OUTPUT_RAIL_I < rx_prot_pkg::SHORT_LIMIT_MV;
      overload_nxt = ADC_IOUT_I >= OVERLOAD_TH_I;
      inloop_nxt = ADC_RECTIFIED_RAIL_I < RECTIFIED_RAIL_MIN_I;
      tuser_nxt[0] = ADC_TEMP_RECT_I >= TEMP_TH_I[0*TW +: TW];
      tuser_nxt[1] = ADC_TEMP_REG_I >= TEMP_TH_I[1*TW +: TW];
      tuser_nxt[2] = ADC_TEMP_COIL_I >= TEMP_TH_I[2*TW +: TW];
      tick_nxt = ~tick_r;
      if (ADC_TEMP_RECT_I >= rx_prot_pkg::TEMP_HARD_C ||
          ADC_TEMP_REG_I >= rx_prot_pkg::TEMP_HARD_C) begin
        hot_nxt = 1'b1;
      end else if (ADC_TEMP_RECT_I < rx_prot_pkg::TEMP_HARD_C - rx_prot_pkg::TEMP_HYST_C &&
                   ADC_TEMP_REG_I < rx_prot_pkg::TEMP_HARD_C - rx_prot_pkg::TEMP_HYST_C) begin
        hot_nxt = 1'b0;
      end
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      temp_rect_r <= '0;
      temp_reg_r <= '0;
      vmin_r <= '0;
      {adj_ovp_r, ilim_r, short_r, overload_r, inloop_r, hot_r, tick_r} <= '0;
      tuser_r <= '0;
    end else begin
      temp_rect_r <= temp_rect_nxt;
      temp_reg_r <= temp_reg_nxt;
      vmin_r <= vmin_nxt;
      {adj_ovp_r, ilim_r, short_r, overload_r, inloop_r, hot_r, tick_r} <=
        {adj_ovp_nxt, ilim_nxt, short_nxt, overload_nxt, inloop_nxt, hot_nxt, tick_nxt};
      tuser_r <= tuser_nxt;
    end
  end

  // Event vector and per-source actions
  logic [NI-1:0] ev, rise, pkt_want, disc_want, int_en, keep_vec;
  assign ev = {overload_r, short_r, ilim_r, tuser_r, adj_ovp_r, fixed_ovp_s,
               hard_ovp_s | hot_r};
  for (genvar i = 0; i < NI; i++) begin : g_act
    assign pkt_want[i] = ACTION_I[i*rx_prot_pkg::ACT_W + rx_prot_pkg::ACT_PACKET];
    assign disc_want[i] = ACTION_I[i*rx_prot_pkg::ACT_W + rx_prot_pkg::ACT_DISC];
    assign int_en[i] = IRQ_MAP_I[i] | ACTION_I[i*rx_prot_pkg::ACT_W + rx_prot_pkg::ACT_INT];
  end

  // Pin function decode
  logic [PINS-1:0] pin_out_nxt, pin_oe_nxt, inhibit_vec;
  logic irq_r, out_en_r, ready_r;
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    wire logic [rx_prot_pkg::FUNC_W-1:0] fsel = PIN_FUNC_SEL_I[p*rx_prot_pkg::FUNC_W +:
                                                              rx_prot_pkg::FUNC_W];
    assign inhibit_vec[p] = (fsel == rx_prot_pkg::PIN_FUNC_OUTPUT_INHIBIT_IN) &&
                            sync2_r[rx_prot_pkg::S_PIN0 + p];
    always_comb begin
      pin_out_nxt[p] = 1'b0;
      pin_oe_nxt[p] = 1'b0;
      unique case (fsel)
        rx_prot_pkg::PIN_FUNC_IRQ_INV_OPENDRAIN: begin
          pin_oe_nxt[p] = irq_r;
        end
        rx_prot_pkg::PIN_FUNC_IRQ_INV_PUSHPULL: begin
          pin_out_nxt[p] = ~irq_r;
          pin_oe_nxt[p] = 1'b1;
        end
        rx_prot_pkg::PIN_FUNC_OUTPUT_STATUS: begin
          pin_out_nxt[p] = out_en_r;
          pin_oe_nxt[p] = 1'b1;
        end
        rx_prot_pkg::PIN_FUNC_OUTPUT_STATUS_INV: begin
          pin_out_nxt[p] = ~out_en_r;
          pin_oe_nxt[p] = 1'b1;
        end
        rx_prot_pkg::PIN_FUNC_OUTPUT_STATUS_INV_OD: begin
          pin_oe_nxt[p] = out_en_r;
        end
        rx_prot_pkg::PIN_FUNC_SAMPLE_TICK: begin
          pin_out_nxt[p] = tick_r;
          pin_oe_nxt[p] = 1'b1;
        end
        rx_prot_pkg::PIN_FUNC_CORE_READY_N: begin
          pin_out_nxt[p] = ~ready_r;
          pin_oe_nxt[p] = 1'b1;
        end
        default: begin
          pin_oe_nxt[p] = 1'b0;
        end
      endcase
    end
  end

  // Protection group
  logic clamp_r, clamp_nxt, ext_n_r, ext_n_nxt, pkt_r, pkt_nxt;
  logic reg_dis_r, reg_dis_nxt, out_en_nxt, irq_nxt, int_n_nxt, int_oe_nxt;
  logic int_n_r, int_oe_r, started_r, reload_r, ready_nxt;
  logic [NI-1:0] status_r, status_nxt, prev_r;
  logic [RW-1:0] target_r, target_nxt, dummy_r, dummy_nxt, dummy_goal;
  logic [PINS-1:0] pin_out_r, pin_oe_r;
  assign keep_vec = status_r & ~IRQ_CLEAR_I;
  assign rise = ev & ~prev_r;
  always_comb begin
    clamp_nxt = clamp_r;
    if (ev[rx_prot_pkg::IRQ_HARD_OVP]) begin
      clamp_nxt = 1'b1;
    end else if (!five_good_s) begin
      clamp_nxt = 1'b0;
    end
    ext_n_nxt = ~(fixed_ovp_s | adj_ovp_r);
    status_nxt = keep_vec | ev;
    pkt_nxt = |(rise & pkt_want);
    reg_dis_nxt = short_r | (reg_dis_r & status_r[rx_prot_pkg::IRQ_SHORT]);
    out_en_nxt = ~(reg_dis_r | (|(status_r & disc_want)) | (|inhibit_vec));
    irq_nxt = |(status_r & int_en);
    int_n_nxt = INT_OPEN_DRAIN_I ? 1'b0 : ~irq_r;
    int_oe_nxt = INT_OPEN_DRAIN_I ? irq_r : 1'b1;
    ready_nxt = ready_r | (started_r & CONFIG_DONE_I);
    target_nxt = target_r;
    if (ADC_VALID_I) begin
      if (ilim_r) begin
        target_nxt = (target_r > rx_prot_pkg::TARGET_STEP_MV) ?
                     target_r - rx_prot_pkg::TARGET_STEP_MV : '0;
      end else if (target_r + rx_prot_pkg::TARGET_STEP_MV < OUTPUT_RAIL_NOMINAL_I) begin
        target_nxt = target_r + rx_prot_pkg::TARGET_STEP_MV;
      end else begin
        target_nxt = OUTPUT_RAIL_NOMINAL_I;
      end
    end
    dummy_goal = (ADC_IOUT_I < DUMMY_CURRENT_I) ? DUMMY_CURRENT_I - ADC_IOUT_I : '0;
    dummy_nxt = dummy_r;
    if (ADC_VALID_I) begin
      if (dummy_r <= dummy_goal) begin
        dummy_nxt = dummy_goal;
      end else begin
        dummy_nxt = dummy_r - rx_prot_pkg::DUMMY_STEP_MA;
      end
    end
  end
  always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      {clamp_r, pkt_r, reg_dis_r, irq_r, int_oe_r, started_r, reload_r, ready_r} <= '0;
      {ext_n_r, out_en_r, int_n_r} <= '1;
      status_r <= '0;
      prev_r <= '0;
      target_r <= '0;
      dummy_r <= '0;
      pin_out_r <= '0;
      pin_oe_r <= '0;
    end else begin
      {clamp_r, pkt_r, reg_dis_r, irq_r, int_oe_r} <=
        {clamp_nxt, pkt_nxt, reg_dis_nxt, irq_nxt, int_oe_nxt};
      started_r <= 1'b1;
      reload_r <= ~started_r;
      ready_r <= ready_nxt;
      {ext_n_r, out_en_r, int_n_r} <= {ext_n_nxt, out_en_nxt, int_n_nxt};
      status_r <= status_nxt;
      prev_r <= ev;
      target_r <= target_nxt;
      dummy_r <= dummy_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign PIN_O = pin_out_r;
  assign PIN_OE_O = pin_oe_r;
  assign INT_N_O = int_n_r;
  assign INT_OE_O = int_oe_r;
  assign COIL_CLAMP_O = clamp_r;
  assign EXT_CLAMP_N_O = ext_n_r;
  assign END_TRANSFER_PACKET_O = pkt_r;
  assign REG_DISABLE_O = reg_dis_r;
  assign OUTPUT_ENABLED_O = out_en_r;
  assign CURRENT_LOOP_O = ilim_r;
  assign INPUT_LOOP_O = inloop_r;
  assign OUTPUT_RAIL_TARGET_O = target_r;
  assign RECTIFIED_RAIL_MIN_O = vmin_r;
  assign DUMMY_CURRENT_O = dummy_r;
  assign TEMP_RECT_O = temp_rect_r;
  assign TEMP_REG_O = temp_reg_r;
  assign IRQ_STATUS_O = status_r;
  assign CONFIG_RELOAD_O = reload_r;
  assign CORE_READY_O = ready_r;

  property p_clamp_set;
    hard_ovp_s |=> COIL_CLAMP_O;
  endproperty
  a_clamp_set: assert property (p_clamp_set) else $error("clamp not set");
  property p_clamp_hold;
    COIL_CLAMP_O && five_good_s |=> COIL_CLAMP_O;
  endproperty
  a_clamp_hold: assert property (p_clamp_hold) else $error("clamp dropped");
  property p_clamp_free;
    COIL_CLAMP_O && !five_good_s && !hard_ovp_s && !hot_r |=> !COIL_CLAMP_O;
  endproperty
  a_clamp_free: assert property (p_clamp_free) else $error("clamp stuck");
  property p_ext;
    (fixed_ovp_s || adj_ovp_r) |=> !EXT_CLAMP_N_O;
  endproperty
  a_ext: assert property (p_ext) else $error("external clamp idle");
  property p_hot;
    ADC_VALID_I && ADC_TEMP_REG_I >= rx_prot_pkg::TEMP_HARD_C |=> ##1 COIL_CLAMP_O;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal clamp missing");
  property p_short;
    ADC_VALID_I && ADC_OUTPUT_RAIL_I < rx_prot_pkg::SHORT_LIMIT_MV |=> ##1 REG_DISABLE_O;
  endproperty
  a_short: assert property (p_short) else $error("regulator not disabled");
  property p_sticky;
    1'b1 |=> ((IRQ_STATUS_O & $past(keep_vec)) == $past(keep_vec));
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");
  property p_packet;
    $rose(COIL_CLAMP_O) && $past(ACTION_I[rx_prot_pkg::ACT_PACKET]) |-> END_TRANSFER_PACKET_O;
  endproperty
  a_packet: assert property (p_packet) else $error("packet request wrong");
  property p_reload;
    $rose(started_r) |-> CONFIG_RELOAD_O ##1 !CONFIG_RELOAD_O;
  endproperty
  a_reload: assert property (p_reload) else $error("reload pulse wrong");
endmodule : rx_protection_event_manager

// >>> tb/rx_prot_far_side.sv
// Far side model: converter sample strobe, pin wiring and interrupt line.
// Assumes pins and the interrupt line carry pull-ups; the bench holds readings.
`timescale 1ns/1ps
module rx_prot_far_side #(
  parameter int PERIOD = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] pin_drive_i,
  input wire logic [5:0] pin_oe_i,
  input wire logic [5:0] ext_en_i,
  input wire logic [5:0] ext_val_i,
  input wire logic int_drive_i,
  input wire logic int_oe_i,
  output logic [5:0] pin_wire_o,
  output logic int_wire_o,
  output logic valid_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  // Sample strobe, one cycle every PERIOD cycles
  always_comb cnt_nxt = (cnt_r == 4'(PERIOD - 1)) ? 4'h0 : cnt_r + 4'h1;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign valid_o = (cnt_r == 4'h0) & ~rst_i;
  // Pin level from device drive, host drive or pull-up
  assign pin_wire_o = (pin_oe_i & pin_drive_i) | (~pin_oe_i & ~(ext_en_i & ~ext_val_i));
  assign int_wire_o = int_oe_i ? int_drive_i : 1'b1;
endmodule : rx_prot_far_side

// >>> tb/test_rx_protection_event_manager.sv
// Self-checking bench for the receiver protection and event manager.
// Assumes the far side model for sample strobes and pin wiring.
`timescale 1ns/1ps
module test_rx_protection_event_manager;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hard_ovp = 1'b0, fixed_ovp = 1'b0, five_good = 1'b1, cfg_done = 1'b0, od = 1'b0;
  logic [15:0] vr = 16'h157C, vo = 16'h1388, io = 16'h0000;
  logic [15:0] nom = 16'h1388, vmin_cfg = 16'h1194, dum_cfg = 16'h0064;
  logic [15:0] adj_th = 16'h2EE0, ovl_th = 16'h03E8;
  logic [23:0] temp_th = 24'h50_5A64;
  logic [7:0] tr = 8'h19, tg = 8'h19, tc = 8'h19;
  logic [26:0] action = 27'h000_0000;
  logic [8:0] irq_map = 9'h000, irq_clr = 9'h000;
  logic [47:0] func = 48'h0807_0605_0403;
  logic [5:0] ext_en = 6'h04, ext_val = 6'h00;
  logic adc_valid, int_wire, int_n, int_oe, coil, ext_n, pkt, reg_dis, out_en;
  logic cur_loop, in_loop, reload, ready;
  logic [5:0] pin_wire, pin_o, pin_oe;
  logic [15:0] target, vmin, dummy;
  logic [7:0] trect, treg;
  logic [8:0] status;
  int num_errors = 0;
  int total_checks = 0;
  int pkt_cnt = 0;
  int e0;
  logic v;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (pkt === 1'b1) pkt_cnt++;

  rx_protection_event_manager dut (
    .SYS_CLK_I(sys_clk), .RESET_I(rst), .HARD_OVP_I(hard_ovp), .FIXED_SOFT_OVP_I(fixed_ovp),
    .FIVE_V_GOOD_I(five_good), .ADC_VALID_I(adc_valid), .ADC_RECTIFIED_RAIL_I(vr),
    .ADC_OUTPUT_RAIL_I(vo),
    .ADC_IOUT_I(io), .ADC_TEMP_RECT_I(tr), .ADC_TEMP_REG_I(tg), .ADC_TEMP_COIL_I(tc),
    .OUTPUT_RAIL_NOMINAL_I(nom), .RECTIFIED_RAIL_MIN_I(vmin_cfg), .DUMMY_CURRENT_I(dum_cfg),
    .ADJ_OVP_TH_I(adj_th), .OVERLOAD_TH_I(ovl_th), .TEMP_TH_I(temp_th), .ACTION_I(action),
    .IRQ_MAP_I(irq_map), .IRQ_CLEAR_I(irq_clr), .INT_OPEN_DRAIN_I(od),
    .CONFIG_DONE_I(cfg_done), .PIN_FUNC_SEL_I(func), .PIN_I(pin_wire), .PIN_O(pin_o),
    .PIN_OE_O(pin_oe), .INT_N_O(int_n), .INT_OE_O(int_oe), .COIL_CLAMP_O(coil),
    .EXT_CLAMP_N_O(ext_n), .END_TRANSFER_PACKET_O(pkt), .REG_DISABLE_O(reg_dis),
    .OUTPUT_ENABLED_O(out_en), .CURRENT_LOOP_O(cur_loop), .INPUT_LOOP_O(in_loop),
    .OUTPUT_RAIL_TARGET_O(target), .RECTIFIED_RAIL_MIN_O(vmin), .DUMMY_CURRENT_O(dummy),
    .TEMP_RECT_O(trect), .TEMP_REG_O(treg), .IRQ_STATUS_O(status),
    .CONFIG_RELOAD_O(reload), .CORE_READY_O(ready)
  );

  rx_prot_far_side far (
    .clk_i(sys_clk), .rst_i(rst), .pin_drive_i(pin_o), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .int_drive_i(int_n), .int_oe_i(int_oe), .pin_wire_o(pin_wire),
    .int_wire_o(int_wire), .valid_o(adc_valid)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  // Waits for n sample strobes, then for all answers to land
  task automatic samp(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      while (adc_valid !== 1'b1) @(posedge sys_clk);
    end
    settle(5);
  endtask : samp

  task automatic clr(input logic [8:0] m);
    @(posedge sys_clk);
    irq_clr <= m;
    @(posedge sys_clk);
    irq_clr <= 9'h000;
    settle(4);
  endtask : clr

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    complete_run;
  end

  initial begin
    settle(4);
    check("ext_n rst", ext_n, 1);
    check("out_en rst", out_en, 1);
    check("int_n rst", int_n, 1);
    check("coil rst", coil, 0);
    @(posedge sys_clk) rst <= 1'b0;
    settle(1);
    check("reload", reload, 1);
    settle(1);
    check("reload end", reload, 0);
    @(posedge sys_clk) cfg_done <= 1'b1;
    samp(260);
    check("ready", ready, 1);
    check("target", target, 16'h1388);
    check("dummy", dummy, 16'h0064);
    check("trect", trect, 8'h19);
    check("in_loop", in_loop, 0);
    check("vmin", vmin, 16'h1194);
    check("int_wire", int_wire, 1);
    check("int_oe pp", int_oe, 1);
    check("pin0 idle", pin_wire[0], 1);
    check("pin1 idle", pin_o[1], 1);
    check("pin3 on", pin_o[3], 1);
    check("pin4 on", pin_o[4], 0);
    check("pin5 on", pin_wire[5], 0);
    @(posedge sys_clk) io <= 16'h003C;
    samp(70);
    check("dummy fade", dummy, 16'h0028);
    @(posedge sys_clk) vr <= 16'h0FA0;
    samp(1);
    check("in_loop low", in_loop, 1);
    @(posedge sys_clk);
    vr <= 16'h157C;
    io <= 16'h0640;
    irq_map <= 9'h040;
    od <= 1'b1;
    samp(2);
    check("target lim", target, 16'h136F);
    check("cur_loop", cur_loop, 1);
    check("st6", status[6], 1);
    check("st8", status[8], 1);
    check("int_oe od", int_oe, 1);
    check("int_wire od", int_wire, 0);
    check("pin0 irq", pin_wire[0], 0);
    check("pin1 irq", pin_o[1], 0);
    samp(1);
    check("target lim2", target, 16'h1356);
    @(posedge sys_clk) io <= 16'h0000;
    samp(2);
    check("target up", target, 16'h1356);
    check("cur_loop off", cur_loop, 0);
    check("st6 held", status[6], 1);
    clr(9'h140);
    check("st cleared", status, 9'h000);
    check("int_oe idle", int_oe, 0);
    check("pin0 rel", pin_wire[0], 1);
    @(posedge sys_clk) vo <= 16'h03E8;
    samp(1);
    check("reg_dis", reg_dis, 1);
    check("st7", status[7], 1);
    check("out_en short", out_en, 0);
    check("pin3 off", pin_o[3], 0);
    check("pin4 off", pin_o[4], 1);
    check("pin5 off", pin_wire[5], 1);
    @(posedge sys_clk) vo <= 16'h1388;
    samp(1);
    check("reg_dis held", reg_dis, 1);
    clr(9'h080);
    settle(4);
    check("reg_dis off", reg_dis, 0);
    check("out_en back", out_en, 1);
    @(posedge sys_clk) ext_val <= 6'h04;
    settle(6);
    check("inhibit", out_en, 0);
    @(posedge sys_clk) ext_val <= 6'h00;
    settle(6);
    check("enable", out_en, 1);
    e0 = pkt_cnt;
    @(posedge sys_clk);
    action <= 27'h000_0001;
    hard_ovp <= 1'b1;
    settle(4);
    check("coil", coil, 1);
    check("st0", status[0], 1);
    @(posedge sys_clk) hard_ovp <= 1'b0;
    settle(10);
    check("coil held", coil, 1);
    check("end packet", pkt_cnt - e0, 1);
    @(posedge sys_clk) five_good <= 1'b0;
    settle(4);
    check("coil rel", coil, 0);
    @(posedge sys_clk) five_good <= 1'b1;
    clr(9'h001);
    @(posedge sys_clk) fixed_ovp <= 1'b1;
    settle(4);
    check("ext fixed", ext_n, 0);
    check("st1", status[1], 1);
    @(posedge sys_clk) fixed_ovp <= 1'b0;
    @(posedge sys_clk) vr <= 16'h32C8;
    samp(1);
    check("ext adj", ext_n, 0);
    check("st2", status[2], 1);
    @(posedge sys_clk) vr <= 16'h157C;
    samp(1);
    clr(9'h006);
    check("ext rel", ext_n, 1);
    @(posedge sys_clk);
    tr <= 8'h64;
    tg <= 8'h7D;
    tc <= 8'h50;
    samp(1);
    check("coil hot", coil, 1);
    check("st temp", status, 9'h039);
    check("trect hot", trect, 8'h64);
    check("treg", treg, 8'h7D);
    @(posedge sys_clk);
    five_good <= 1'b0;
    tg <= 8'h78;
    samp(1);
    check("coil hyst", coil, 1);
    @(posedge sys_clk) tg <= 8'h72;
    samp(1);
    check("coil cool", coil, 0);
    @(posedge sys_clk);
    tr <= 8'h19;
    tg <= 8'h19;
    tc <= 8'h19;
    five_good <= 1'b1;
    samp(1);
    clr(9'h039);
    check("st none", status, 9'h000);
    @(posedge sys_clk) func <= 48'h0807_0600_1D0F;
    samp(1);
    check("pin2 unused", pin_oe[2], 0);
    check("pin1 ready", pin_o[1], 0);
    check("pin1 oe", pin_oe[1], 1);
    v = pin_o[0];
    samp(1);
    check("pin0 tick", pin_o[0], !v);
    check("pin0 oe", pin_oe[0], 1);
    complete_run;
  end
endmodule : test_rx_protection_event_manager
